// File: shared/dids_pkg.sv
// Operation
// - two read-only 24-bit identity words sit from the program-space base, top byte reads zero.
// - the first word, at the base, returns a fixed family-and-part value in bits 15:0.
// - the second word, two locations higher, returns a fixed major/minor silicon revision.
// - both words are read through the table-read path, not the data bus.
// - the programming data pin takes serial data in and drives device information out on command.
// - while programming, any of the three clock/data pin pairs is accepted with no selection.
// - debug traffic uses the same pins: one carries the debug clock, the other the debug data.
// - the debug pair is chosen by the two-bit channel-select field in bits 1:0 of the debug config.
// - with debug enabled, the first 80 bytes of data RAM and two I/O pins are withheld.
package dids_pkg;
  localparam logic [23:0] PART_IDENTIFIER_ADDR  = 24'hff_0000;
  localparam logic [23:0] SILICON_REVISION_ADDR = 24'hff_0002;
  localparam int          ID_WIDTH              = 24;
  localparam int          ID_VALUE_WIDTH        = 16;
  localparam int          CHAN_SEL_LSB          = 0;
  localparam int          CHAN_SEL_WIDTH        = 2;
  localparam int          NUM_PAIRS             = 3;
  localparam int          DEBUG_RAM_BYTES       = 80;
  localparam int          RAM_ADDR_WIDTH        = 16;
  localparam int          CMD_BITS              = 4;
  localparam int          ADDR_BITS             = 24;
  localparam logic [3:0]  CMD_READ              = 4'h1;
  localparam logic [3:0]  CMD_WRITE             = 4'h2;
  // selection codes of the debug pair; 2'b00 reserved
  localparam logic [1:0]  CHAN_PAIR1            = 2'h3;
  localparam logic [1:0]  CHAN_PAIR2            = 2'h2;
  localparam logic [1:0]  CHAN_PAIR3            = 2'h1;
  // arbitrary neutral identity values
  localparam logic [15:0] PART_ID_DEFAULT       = 16'h0a5c;
  localparam logic [15:0] REVISION_DEFAULT      = 16'h0101;
endpackage

// File: core/dids_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dids_pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end
  assign sync_out = sync_reg;
endmodule
`default_nettype wire

// File: core/dids_top.sv
`timescale 1ns/1ps
`default_nettype none
module dids_top #(
  parameter logic [15:0] PART_ID  = dids_pkg::PART_ID_DEFAULT,
  parameter logic [15:0] REVISION = dids_pkg::REVISION_DEFAULT
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  // table-read port from the core
  input  wire logic        tbl_rd,
  input  wire logic        tbl_wr,
  input  wire logic [23:0] tbl_addr,
  output var  logic [23:0] tbl_rdata,
  output var  logic        tbl_rvalid,
  // debug configuration, loaded from configuration space
  input  wire logic        debug_enable,
  input  wire logic [1:0]  debug_channel_select,
  input  wire logic        prog_mode,
  // three clock/data pin pairs
  input  wire logic [2:0]  prog_debug_clock_pin,
  input  wire logic [2:0]  prog_debug_data_pin_in,
  output var  logic [2:0]  prog_debug_data_pin_out,
  output var  logic [2:0]  prog_debug_data_pin_oe,
  // reservation indications
  input  wire logic [15:0] ram_addr,
  output var  logic        ram_reserved,
  output var  logic [2:0]  pins_reserved,
  output var  logic [1:0]  active_pair,
  output var  logic        link_active
);
  typedef enum logic [3:0] {
    ST_CMD   = 4'b0001,
    ST_ADDR  = 4'b0010,
    ST_SHOUT = 4'b0100,
    ST_IGN   = 4'b1000
  } dids_state_t;

  function automatic logic [23:0] id_lookup(input logic [23:0] a);
    if (a == dids_pkg::PART_IDENTIFIER_ADDR)
      id_lookup = {8'h00, PART_ID};
    else if (a == dids_pkg::SILICON_REVISION_ADDR)
      id_lookup = {8'h00, REVISION};
    else
      id_lookup = 24'h00_0000;
  endfunction

  logic [2:0] clk_s;
  logic [2:0] dat_s;
  dids_pin_sync #(.WIDTH(6)) u_sync (
    .clock    (clock),
    .rst_n    (rst_n),
    .async_in ({prog_debug_clock_pin, prog_debug_data_pin_in}),
    .sync_out ({clk_s, dat_s})
  );

  // table-read path; writes ignored
  logic [23:0] rdata_reg, rdata_next;
  logic        rvalid_reg, rvalid_next;
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = tbl_rd;
    if (tbl_rd) begin
      rdata_next = id_lookup(tbl_addr);
    end
    // tbl_wr has no effect on stored values
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 24'h00_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // pair selection
  logic [1:0] sel_idx;
  logic       sel_ok;
  always_comb begin
    sel_ok  = 1'b1;
    unique case (debug_channel_select)
      dids_pkg::CHAN_PAIR1: sel_idx = 2'd0;
      dids_pkg::CHAN_PAIR2: sel_idx = 2'd1;
      dids_pkg::CHAN_PAIR3: sel_idx = 2'd2;
      default: begin
        sel_idx = 2'd0;
        sel_ok  = 1'b0;
      end
    endcase
  end

  // link engine; partner supplies the clock
  dids_state_t st_reg, st_next;
  logic [1:0]  pair_reg, pair_next;
  logic        lock_reg, lock_next;
  logic [2:0]  clk_d_reg;
  logic [4:0]  cnt_reg, cnt_next;
  logic [23:0] sh_reg, sh_next;
  logic [3:0]  cmd_reg, cmd_next;
  logic        dout_reg, dout_next;
  logic        doe_reg, doe_next;
  logic [2:0]  oe_reg, oe_next;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic        any_rise;
  logic        r_sel, f_sel, d_sel;
  logic [1:0]  pick;

  assign rise = clk_s & ~clk_d_reg;
  assign fall = ~clk_s & clk_d_reg;
  assign any_rise = |rise;

  always_comb begin
    pick = sel_idx;
    if (prog_mode) begin
      // first pair to clock wins
      if (rise[0]) pick = 2'd0;
      else if (rise[1]) pick = 2'd1;
      else pick = 2'd2;
    end
  end

  assign r_sel = rise[pair_reg];
  assign f_sel = fall[pair_reg];
  assign d_sel = dat_s[pair_reg];

  always_comb begin
    st_next   = st_reg;
    pair_next = pair_reg;
    lock_next = lock_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    cmd_next  = cmd_reg;
    dout_next = dout_reg;
    doe_next  = doe_reg;
    // a new debug selection drops the old lock; the next cycle locks the new pair
    if (!prog_mode && (!(debug_enable && sel_ok) || (lock_reg && pair_reg != sel_idx))) begin
      lock_next = 1'b0;
      st_next   = ST_CMD;
      cnt_next  = 5'd0;
      doe_next  = 1'b0;
    end else if (!lock_reg) begin
      if (prog_mode ? any_rise : 1'b1) begin
        pair_next = pick;
        lock_next = 1'b1;
      end
    end else begin
      unique case (st_reg)
        ST_CMD: if (r_sel) begin
          cmd_next = {cmd_reg[2:0], d_sel};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(dids_pkg::CMD_BITS - 1)) begin
            cnt_next = 5'd0;
            st_next  = ST_ADDR;
          end
        end
        ST_ADDR: if (r_sel) begin
          sh_next  = {sh_reg[22:0], d_sel};
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(dids_pkg::ADDR_BITS - 1)) begin
            cnt_next = 5'd0;
            if (cmd_reg == dids_pkg::CMD_READ) begin
              sh_next = id_lookup({sh_reg[22:0], d_sel});
              st_next = ST_SHOUT;
            end else begin
              // identity words are not writable
              st_next = ST_IGN;
            end
          end
        end
        ST_SHOUT: if (f_sel) begin
          doe_next  = 1'b1;
          dout_next = sh_reg[23];
          sh_next   = {sh_reg[22:0], 1'b0};
          cnt_next  = cnt_reg + 5'd1;
          if (cnt_reg == 5'(dids_pkg::ID_WIDTH)) begin
            doe_next = 1'b0;
            cnt_next = 5'd0;
            st_next  = ST_CMD;
          end
        end
        ST_IGN: if (r_sel) begin
          cnt_next = cnt_reg + 5'd1;
          if (cnt_reg == 5'(dids_pkg::ID_WIDTH - 1)) begin
            cnt_next = 5'd0;
            st_next  = ST_CMD;
          end
        end
        default: st_next = ST_CMD;
      endcase
    end
    // enable registered per pin so the pad control leaves a flip-flop directly
    oe_next = doe_next ? (3'b001 << pair_next) : 3'b000;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg    <= ST_CMD;
      pair_reg  <= 2'd0;
      lock_reg  <= 1'b0;
      clk_d_reg <= 3'b000;
      cnt_reg   <= 5'd0;
      sh_reg    <= 24'h00_0000;
      cmd_reg   <= 4'h0;
      dout_reg  <= 1'b0;
      doe_reg   <= 1'b0;
      oe_reg    <= 3'b000;
    end else begin
      st_reg    <= st_next;
      pair_reg  <= pair_next;
      lock_reg  <= lock_next;
      clk_d_reg <= clk_s;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      cmd_reg   <= cmd_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
      oe_reg    <= oe_next;
    end
  end

  // reservations while debugging
  logic       ramres_reg, ramres_next;
  logic [2:0] pres_reg, pres_next;
  always_comb begin
    ramres_next = debug_enable && sel_ok &&
                  (ram_addr < 16'(dids_pkg::DEBUG_RAM_BYTES));
    pres_next   = 3'b000;
    if (debug_enable && sel_ok) pres_next[sel_idx] = 1'b1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ramres_reg <= 1'b0;
      pres_reg   <= 3'b000;
    end else begin
      ramres_reg <= ramres_next;
      pres_reg   <= pres_next;
    end
  end

  assign tbl_rdata               = rdata_reg;
  assign tbl_rvalid              = rvalid_reg;
  assign prog_debug_data_pin_out = {3{dout_reg}};
  assign prog_debug_data_pin_oe  = oe_reg;
  assign ram_reserved            = ramres_reg;
  assign pins_reserved           = pres_reg;
  assign active_pair             = pair_reg;
  assign link_active             = lock_reg;
endmodule
`default_nettype wire

// File: tb/dids_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dids_asserts #(
  parameter logic [15:0] PART_ID  = 16'h0000,
  parameter logic [15:0] REVISION = 16'h0000
) (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        tbl_rd,
  input wire logic [23:0] tbl_addr,
  input wire logic [23:0] tbl_rdata,
  input wire logic        tbl_rvalid,
  input wire logic        debug_enable,
  input wire logic [1:0]  debug_channel_select,
  input wire logic [15:0] ram_addr,
  input wire logic        ram_reserved,
  input wire logic [2:0]  pins_reserved,
  input wire logic [2:0]  prog_debug_data_pin_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic dbg;
  assign dbg = debug_enable && (debug_channel_select != 2'h0);
  sequence s_rd_part;
    tbl_rd && tbl_addr == dids_pkg::PART_IDENTIFIER_ADDR;
  endsequence
  sequence s_rd_rev;
    tbl_rd && tbl_addr == dids_pkg::SILICON_REVISION_ADDR;
  endsequence
  property p_ack; tbl_rd |=> tbl_rvalid; endproperty
  property p_upper; tbl_rvalid |-> tbl_rdata[23:16] == 8'h00; endproperty
  property p_part; s_rd_part |=> tbl_rdata == {8'h00, PART_ID}; endproperty
  property p_rev; s_rd_rev |=> tbl_rdata == {8'h00, REVISION}; endproperty
  property p_hold; !tbl_rd |=> $stable(tbl_rdata) && !tbl_rvalid; endproperty
  property p_ram; dbg && ram_addr < 16'h0050 |=> ram_reserved; endproperty
  property p_ram_free; !dbg |=> !ram_reserved && pins_reserved == 3'h0; endproperty
  property p_pins; dbg |=> $onehot(pins_reserved); endproperty
  property p_oe; $onehot0(prog_debug_data_pin_oe); endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  a_upper: assert property (p_upper) else $error("upper byte set");
  a_part: assert property (p_part) else $error("part word wrong");
  a_rev: assert property (p_rev) else $error("revision word wrong");
  a_hold: assert property (p_hold) else $error("data moved without read");
  a_ram: assert property (p_ram) else $error("ram not withheld");
  a_ram_free: assert property (p_ram_free) else $error("withheld without debug");
  a_pins: assert property (p_pins) else $error("pair not one-hot");
  a_oe: assert property (p_oe) else $error("several data pins driven");
endmodule
bind dids_top dids_asserts #(.PART_ID(PART_ID), .REVISION(REVISION)) u_chk (
  .clock(clock), .rst_n(rst_n), .tbl_rd(tbl_rd), .tbl_addr(tbl_addr),
  .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid), .debug_enable(debug_enable),
  .debug_channel_select(debug_channel_select), .ram_addr(ram_addr),
  .ram_reserved(ram_reserved), .pins_reserved(pins_reserved),
  .prog_debug_data_pin_oe(prog_debug_data_pin_oe));
`default_nettype wire

// File: tb/dids_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module dids_prog_model (
  input  wire logic [2:0] line,
  output var  logic [2:0] pclk,
  output var  logic [2:0] pdat
);
  initial begin
    pclk = 3'h0;
    pdat = 3'h0;
  end
  // clock stands low between frames
  task automatic frame(input int p, input bit lock, input logic [3:0] cmd,
                       input logic [23:0] a, input logic [23:0] wd, output logic [23:0] rd);
    logic [51:0] sh;
    sh = {cmd, a, wd};
    rd = 24'h00_0000;
    for (int i = (lock ? 52 : 51); i >= 0; i--) begin
      if (i < 24 && cmd == dids_pkg::CMD_READ) begin
        pdat[p] = ~pdat[p]; // released line is not held
      end else begin
        pdat[p] = (i > 51) ? 1'b0 : sh[i];
      end
      #100 pclk[p] = 1'b1;
      if (i < 24) begin
        rd[i] = line[p];
      end
      #100 pclk[p] = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/dids_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module dids_top_test;
  localparam logic [23:0] PART = {8'h00, dids_pkg::PART_ID_DEFAULT};
  localparam logic [23:0] REV  = {8'h00, dids_pkg::REVISION_DEFAULT};
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        tbl_rd = 1'b0;
  logic        tbl_wr = 1'b0;
  logic        dbg_en = 1'b0;
  logic        prog_mode = 1'b0;
  logic [1:0]  chan_sel = 2'h0;
  logic [23:0] tbl_addr = 24'h00_0000;
  logic [15:0] ram_addr = 16'h0000;
  logic [23:0] tbl_rdata, rd;
  logic        tbl_rvalid, ram_res, link_act;
  logic [2:0]  pclk, pdrv, din, dout, doe, pins_res;
  logic [1:0]  act_pair;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #12.5 clock = ~clock;
  assign din = (doe & dout) | (~doe & pdrv);
  dids_top DUT (.clock(clock), .rst_n(rst_n), .tbl_rd(tbl_rd), .tbl_wr(tbl_wr),
    .tbl_addr(tbl_addr), .tbl_rdata(tbl_rdata), .tbl_rvalid(tbl_rvalid),
    .debug_enable(dbg_en), .debug_channel_select(chan_sel), .prog_mode(prog_mode),
    .prog_debug_clock_pin(pclk), .prog_debug_data_pin_in(din),
    .prog_debug_data_pin_out(dout), .prog_debug_data_pin_oe(doe), .ram_addr(ram_addr),
    .ram_reserved(ram_res), .pins_reserved(pins_res), .active_pair(act_pair),
    .link_active(link_act));
  dids_prog_model u_prog (.line(din), .pclk(pclk), .pdat(pdrv));
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tread(input logic [23:0] a, input logic [23:0] e);
    tbl_addr = a;
    tbl_rd = 1'b1;
    @(posedge clock);
    #2;
    chk("rvalid", 24'h1, {23'h0, tbl_rvalid});
    chk("rdata", e, tbl_rdata);
  endtask
  task automatic t_table;
    tread(dids_pkg::PART_IDENTIFIER_ADDR, PART);
    tread(dids_pkg::SILICON_REVISION_ADDR, REV);
    tread(24'hff_0004, 24'h00_0000);
    tbl_rd = 1'b0;
    tbl_wr = 1'b1;
    tbl_addr = dids_pkg::PART_IDENTIFIER_ADDR;
    @(posedge clock);
    #2;
    tbl_wr = 1'b0;
    chk("wr_rvalid", 24'h0, {23'h0, tbl_rvalid});
    chk("wr_rdata", 24'h00_0000, tbl_rdata);
    tread(dids_pkg::PART_IDENTIFIER_ADDR, PART);
    tbl_rd = 1'b0;
  endtask
  task automatic t_debug(input logic [1:0] code, input int k);
    dbg_en = 1'b1;
    chan_sel = code;
    ram_addr = 16'h004f;
    repeat (2) @(posedge clock);
    #2;
    chk("pins", {21'h0, 3'(1 << k)}, {21'h0, pins_res});
    chk("pair", 24'(k), {22'h0, act_pair});
    chk("ram79", 24'h1, {23'h0, ram_res});
    chk("dbg_link", 24'h1, {23'h0, link_act});
    ram_addr = 16'h0050;
    u_prog.frame(k, 1'b0, dids_pkg::CMD_READ, dids_pkg::PART_IDENTIFIER_ADDR, 24'h0, rd);
    chk("dbg_read", PART, rd);
    chk("ram80", 24'h0, {23'h0, ram_res});
  endtask
  task automatic t_off;
    chan_sel = 2'h0;
    ram_addr = 16'h0000;
    repeat (2) @(posedge clock);
    #2;
    chk("off_ram", 24'h0, {23'h0, ram_res});
    chk("off_link", 24'h0, {23'h0, link_act});
    chk("off_pins", 24'h0, {21'h0, pins_res});
    dbg_en = 1'b0;
  endtask
  task automatic t_prog(input int k);
    prog_mode = 1'b1;
    u_prog.frame(k, 1'b1, dids_pkg::CMD_READ, dids_pkg::SILICON_REVISION_ADDR, 24'h0, rd);
    chk("prog_rev", REV, rd);
    chk("prog_pair", 24'(k), {22'h0, act_pair});
    u_prog.frame(k, 1'b0, dids_pkg::CMD_WRITE, dids_pkg::PART_IDENTIFIER_ADDR, 24'h12_3456, rd);
    u_prog.frame(k, 1'b0, dids_pkg::CMD_READ, dids_pkg::PART_IDENTIFIER_ADDR, 24'h0, rd);
    chk("prog_part", PART, rd);
    @(posedge clock);
    #2;
    prog_mode = 1'b0;
    repeat (4) @(posedge clock);
    #2;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #300_000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clock);
    #2;
    rst_n = 1'b1;
    @(posedge clock);
    #2;
    t_table();
    t_debug(dids_pkg::CHAN_PAIR1, 0);
    t_debug(dids_pkg::CHAN_PAIR2, 1);
    t_debug(dids_pkg::CHAN_PAIR3, 2);
    t_off();
    for (int k = 0; k < 3; k++) begin
      t_prog(k);
    end
    complete_run();
  end
endmodule
`default_nettype wire
